// ==== inc/ofm_pkg.sv ====
// Package of register map, field positions and types for the measure block
`default_nettype none
package ofm_pkg;
   // ------------------------------------------------------------------
   // Register byte offsets
   // ------------------------------------------------------------------
   localparam logic [7:0] OFF_TRIM = 8'h84;
   localparam logic [7:0] OFF_CTRL = 8'h94;
   localparam logic [7:0] OFF_COUNT = 8'h98;
   localparam logic [7:0] OFF_IRQ_STATUS = 8'hA0;
   localparam logic [7:0] OFF_IRQ_ENABLE = 8'hA4;
   localparam logic [7:0] OFF_IRQ_CLEAR = 8'hA8;
   // ------------------------------------------------------------------
   // Field positions
   // ------------------------------------------------------------------
   localparam int CTRL_EN_BIT = 31;
   localparam int CTRL_CYC_LSB = 16;
   localparam int CTRL_DONE_BIT = 2;
   localparam int CTRL_SEL_LSB = 0;
   localparam int TRIM_FRAC_LSB = 16;
   localparam int TRIM_COARSE_LSB = 8;
   localparam int TRIM_CUR_LSB = 0;
   localparam int SYNC_STAGES = 2;
   // ------------------------------------------------------------------
   // Reset values and widths
   // ------------------------------------------------------------------
   localparam int CYC_W = 8;
   localparam int CNT_W = 16;
   localparam int SEL_W = 2;
   localparam int FRAC_W = 8;
   localparam logic [1:0] SEL_RESET = 2'h1;
   localparam logic [7:0] FRAC_RESET = 8'h00;
   localparam logic [31:0] ZERO_WORD = 32'h0000_0000;
   // ------------------------------------------------------------------
   // Reference select codes and states
   // ------------------------------------------------------------------
   localparam logic [1:0] SEL_LOW_SPEED_OSC_16KHZ = 2'h0;
   localparam logic [1:0] SEL_CRYSTAL_OSC_32KHZ = 2'h1;
   typedef enum logic [1:0] {
      OFM_IDLE = 2'b00,
      OFM_ARM = 2'b01,
      OFM_COUNT = 2'b10,
      OFM_DONE = 2'b11
   } ofm_state_e;
endpackage : ofm_pkg
`default_nettype wire

// ==== hdl/ofm_ref_sync.sv ====
// Reference clock synchroniser with rising edge detector
`default_nettype none
module ofm_ref_sync #(
   parameter int STAGES = ofm_pkg::SYNC_STAGES
) (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rstn,
   // Reference
   input wire logic ref_in,
   output logic ref_rise
);
   typedef struct packed {
      logic [STAGES-1:0] sync;
      logic last;
   } ofm_sync_s;
   ofm_sync_s st_reg, st_next;

   always_comb begin
      st_next = st_reg;
      st_next.sync = {st_reg.sync[STAGES-2:0], ref_in};
      st_next.last = st_reg.sync[STAGES-1];
   end

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   // Edge taken only from the last stage
   assign ref_rise = st_reg.sync[STAGES-1] & ~st_reg.last;
endmodule : ofm_ref_sync
`default_nettype wire

// ==== hdl/ofm_dither.sv ====
// Signed fractional dither of the oscillator fine trim
`default_nettype none
module ofm_dither #(
   parameter int W = ofm_pkg::FRAC_W
) (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rstn,
   // Trim
   input wire logic [W-1:0] frac,
   input wire logic [7:0] base_trim,
   output logic [7:0] trim_out
);
   typedef struct packed {
      logic [W-1:0] acc;
      logic [7:0] trim;
   } ofm_dith_s;
   ofm_dith_s st_reg, st_next;
   logic [W-1:0] mag;
   logic [W:0] sum;

   always_comb begin
      st_next = st_reg;
      // Magnitude of the signed value, duty is mag/128
      mag = frac[W-1] ? W'(~frac + 1'b1) : frac;
      sum = {1'b0, st_reg.acc[W-2:0]} + {1'b0, mag};
      st_next.acc = {1'b0, sum[W-2:0]};
      st_next.trim = base_trim;
      if (sum[W-1] | sum[W]) begin
         if (frac[W-1]) begin
            st_next.trim = base_trim - 8'h01;
         end else begin
            st_next.trim = base_trim + 8'h01;
         end
      end
   end

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign trim_out = st_reg.trim;
endmodule : ofm_dither
`default_nettype wire

// ==== hdl/ofm_measure.sv ====
// Oscillator frequency measurement and superfine trim, APB slave
// Summary of operation
// - Count clocks over cycles-plus-one reference periods
// - Enable bit starts; clearing disables measurement
// - Disable resets counter and done flag
// - Done reads zero while counting, one after
// - Select 16k, 32k or word-select reference
// - Count register holds measured clock periods
// - Fractional trim is signed, direction by sign
// - Each unit moves one 128th fine step
// - Coarse field is read-only current range
// - Low trim field reads current trim
//
// The APB slave port was left to the implementer.
`default_nettype none
module ofm_measure #(
   parameter int CNT_W = ofm_pkg::CNT_W
) (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rstn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Reference clocks
   input wire logic low_speed_osc_16khz,
   input wire logic crystal_osc_32khz,
   input wire logic i2s_word_select,
   // Oscillator trim
   input wire logic [7:0] coarse_range,
   input wire logic [7:0] oscillator_trim_control,
   output logic [7:0] fine_trim_out,
   // Interrupt
   output logic irq
);
   // ------------------------------------------------------------------
   // State
   // ------------------------------------------------------------------
   typedef struct packed {
      logic enable;
      logic [ofm_pkg::CYC_W-1:0] cycles;
      logic [ofm_pkg::SEL_W-1:0] sel;
      logic [ofm_pkg::FRAC_W-1:0] frac;
      ofm_pkg::ofm_state_e state;
      logic [ofm_pkg::CYC_W:0] periods;
      logic [CNT_W-1:0] count;
      logic done_stat;
      logic done_ien;
      logic [31:0] rdata;
   } ofm_meas_s;
   ofm_meas_s st_reg, st_next;

   logic ref_sel;
   logic ref_rise;
   logic wr_en;
   logic rd_en;
   logic done_evt;
   logic [31:0] rd_word;
   logic [CNT_W-1:0] cnt_inc;
   // Cycles for a new source to pass the whole synchroniser
   localparam int SETTLE = ofm_pkg::SYNC_STAGES + 1;

   // ------------------------------------------------------------------
   // Address decode
   // ------------------------------------------------------------------
   function automatic logic addr_known(input logic [7:0] a);
      return a == ofm_pkg::OFF_TRIM || a == ofm_pkg::OFF_CTRL ||
         a == ofm_pkg::OFF_COUNT || a == ofm_pkg::OFF_IRQ_STATUS ||
         a == ofm_pkg::OFF_IRQ_ENABLE || a == ofm_pkg::OFF_IRQ_CLEAR;
   endfunction : addr_known

   assign wr_en = psel & penable & pwrite & addr_known(paddr);
   assign rd_en = psel & ~penable & ~pwrite;

   // ------------------------------------------------------------------
   // Reference selection and sync
   // ------------------------------------------------------------------
   always_comb begin
      unique case (st_reg.sel)
         ofm_pkg::SEL_LOW_SPEED_OSC_16KHZ: ref_sel = low_speed_osc_16khz;
         ofm_pkg::SEL_CRYSTAL_OSC_32KHZ: ref_sel = crystal_osc_32khz;
         default: ref_sel = i2s_word_select;
      endcase
   end

   ofm_ref_sync u_sync (
      .ref_clk(ref_clk),
      .rstn(rstn),
      .ref_in(ref_sel),
      .ref_rise(ref_rise)
   );

   ofm_dither u_dither (
      .ref_clk(ref_clk),
      .rstn(rstn),
      .frac(st_reg.frac),
      .base_trim(oscillator_trim_control),
      .trim_out(fine_trim_out)
   );

   // ------------------------------------------------------------------
   // Read mux
   // ------------------------------------------------------------------
   always_comb begin
      rd_word = ofm_pkg::ZERO_WORD;
      unique case (paddr)
         ofm_pkg::OFF_TRIM: begin
            rd_word[ofm_pkg::TRIM_FRAC_LSB +: ofm_pkg::FRAC_W] = st_reg.frac;
            rd_word[ofm_pkg::TRIM_COARSE_LSB +: 8] = coarse_range;
            rd_word[ofm_pkg::TRIM_CUR_LSB +: 8] = fine_trim_out;
         end
         ofm_pkg::OFF_CTRL: begin
            rd_word[ofm_pkg::CTRL_EN_BIT] = st_reg.enable;
            rd_word[ofm_pkg::CTRL_CYC_LSB +: ofm_pkg::CYC_W] = st_reg.cycles;
            rd_word[ofm_pkg::CTRL_DONE_BIT] =
               (st_reg.state == ofm_pkg::OFM_DONE);
            rd_word[ofm_pkg::CTRL_SEL_LSB +: ofm_pkg::SEL_W] = st_reg.sel;
         end
         ofm_pkg::OFF_COUNT: rd_word[CNT_W-1:0] = st_reg.count;
         ofm_pkg::OFF_IRQ_STATUS: rd_word[0] = st_reg.done_stat;
         ofm_pkg::OFF_IRQ_ENABLE: rd_word[0] = st_reg.done_ien;
         default: rd_word = ofm_pkg::ZERO_WORD;
      endcase
   end

   // ------------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------------
   assign cnt_inc = st_reg.count + CNT_W'(1);

   always_comb begin
      st_next = st_reg;
      done_evt = 1'b0;
      if (rd_en) begin
         st_next.rdata = rd_word;
      end
      if (wr_en && paddr == ofm_pkg::OFF_CTRL) begin
         st_next.enable = pwdata[ofm_pkg::CTRL_EN_BIT];
         st_next.cycles = pwdata[ofm_pkg::CTRL_CYC_LSB +: ofm_pkg::CYC_W];
         st_next.sel = pwdata[ofm_pkg::CTRL_SEL_LSB +: ofm_pkg::SEL_W];
      end
      if (wr_en && paddr == ofm_pkg::OFF_TRIM) begin
         // Coarse and current trim bits are not stored
         st_next.frac = pwdata[ofm_pkg::TRIM_FRAC_LSB +: ofm_pkg::FRAC_W];
      end
      if (wr_en && paddr == ofm_pkg::OFF_IRQ_ENABLE) begin
         st_next.done_ien = pwdata[0];
      end
      if (wr_en && paddr == ofm_pkg::OFF_IRQ_CLEAR && pwdata[0]) begin
         st_next.done_stat = 1'b0;
      end
      // Disable clears on the write edge, so done never reads stale
      if (!st_next.enable) begin
         st_next.state = ofm_pkg::OFM_IDLE;
         st_next.count = '0;
         st_next.periods = '0;
      end else begin
         unique case (st_reg.state)
            ofm_pkg::OFM_IDLE: begin
               st_next.count = '0;
               st_next.periods = '0;
               st_next.state = ofm_pkg::OFM_ARM;
            end
            ofm_pkg::OFM_ARM: begin
               // Ignore false edges from a source switch
               if (st_reg.periods != SETTLE[ofm_pkg::CYC_W:0]) begin
                  st_next.periods = st_reg.periods + 9'h001;
               end else if (ref_rise) begin
                  st_next.periods = '0;
                  st_next.state = ofm_pkg::OFM_COUNT;
               end
            end
            ofm_pkg::OFM_COUNT: begin
               st_next.count = cnt_inc;
               if (ref_rise) begin
                  st_next.periods = st_reg.periods + 9'h001;
                  if (st_reg.periods == {1'b0, st_reg.cycles}) begin
                     st_next.state = ofm_pkg::OFM_DONE;
                     done_evt = 1'b1;
                  end
               end
            end
            ofm_pkg::OFM_DONE: st_next.state = ofm_pkg::OFM_DONE;
         endcase
      end
      // Set wins over clear
      if (done_evt) begin
         st_next.done_stat = 1'b1;
      end
   end

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         st_reg <= '0;
         st_reg.sel <= ofm_pkg::SEL_RESET;
         st_reg.frac <= ofm_pkg::FRAC_RESET;
      end else begin
         st_reg <= st_next;
      end
   end

   // ------------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------------
   assign prdata = st_reg.rdata;
   assign pready = psel & penable;
   assign pslverr = psel & penable & pwrite & ~addr_known(paddr);
   assign irq = st_reg.done_stat & st_reg.done_ien;
endmodule : ofm_measure
`default_nettype wire

// ==== test/ofm_measure_assertions.sv ====
// Checker of register readback and trim behaviour
`default_nettype none
module ofm_chk (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rstn,
   // APB
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   // Trim
   input wire logic [7:0] coarse_range,
   input wire logic [7:0] oscillator_trim_control,
   input wire logic [7:0] fine_trim_out
);
   timeunit 1ns;
   timeprecision 1ps;
   // ---------------------------------------------------------------
   // Shadow of control writes
   // ---------------------------------------------------------------
   logic en_reg;
   logic [1:0] sel_reg;
   logic [7:0] cyc_reg;
   wire logic wr_ctrl = psel && penable && pwrite
      && paddr == ofm_pkg::OFF_CTRL;
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         en_reg <= 1'b0;
         sel_reg <= ofm_pkg::SEL_RESET;
         cyc_reg <= 8'h00;
      end else if (wr_ctrl) begin
         en_reg <= pwdata[31];
         sel_reg <= pwdata[1:0];
         cyc_reg <= pwdata[23:16];
      end
   end
   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!rstn);
   sequence s_rd(logic [7:0] a);
      psel && !penable && !pwrite && paddr == a;
   endsequence
   a_en_readback: assert property (
      s_rd(ofm_pkg::OFF_CTRL) |=> prdata[31] == $past(en_reg))
      else $error("enable readback wrong");
   a_sel_readback: assert property (
      s_rd(ofm_pkg::OFF_CTRL) |=> prdata[1:0] == $past(sel_reg))
      else $error("reference select readback wrong");
   a_cyc_readback: assert property (
      s_rd(ofm_pkg::OFF_CTRL) |=> prdata[23:16] == $past(cyc_reg))
      else $error("cycle field readback wrong");
   a_done_off: assert property (
      s_rd(ofm_pkg::OFF_CTRL) ##0 !en_reg |=> !prdata[2])
      else $error("done set while disabled");
   a_count_off: assert property (
      s_rd(ofm_pkg::OFF_COUNT) ##0 !en_reg |=> prdata == 32'h0000_0000)
      else $error("count not cleared while disabled");
   a_coarse_view: assert property (
      s_rd(ofm_pkg::OFF_TRIM) |=> prdata[15:8] == $past(coarse_range))
      else $error("coarse readback wrong");
   a_trim_view: assert property (
      s_rd(ofm_pkg::OFF_TRIM) |=> prdata[7:0] == $past(fine_trim_out))
      else $error("trim readback wrong");
   a_dither_near: assert property (
      $past(rstn) && $stable(oscillator_trim_control) |->
      fine_trim_out - oscillator_trim_control + 8'h01 <= 8'h02)
      else $error("dithered trim beyond one step");
endmodule : ofm_chk
bind ofm_measure ofm_chk u_chk (.ref_clk(ref_clk), .rstn(rstn),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
   .pwdata(pwdata), .prdata(prdata), .coarse_range(coarse_range),
   .oscillator_trim_control(oscillator_trim_control),
   .fine_trim_out(fine_trim_out));
`default_nettype wire

// ==== test/ofm_measure_tb.sv ====
// Self-checking bench of the frequency measure block
`default_nettype none
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   logic ref_clk = 1'b0;
   logic rstn = 1'b0;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, err;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0000_0000, prdata, dmy;
   logic pready, pslverr, irq;
   logic lso = 1'b0, xo = 1'b0, ws = 1'b0;
   logic [7:0] fine_trim_out;
   int tick = 0, failures = 0, n_tests = 0;
   always #2 ref_clk = ~ref_clk;
   // References of 40, 20 and 12 clock periods
   always @(posedge ref_clk) begin
      tick <= tick + 1;
      lso <= (tick % 40) < 20;
      xo <= (tick % 20) < 10;
      ws <= (tick % 12) < 6;
   end
   ofm_measure u_dut (.ref_clk(ref_clk), .rstn(rstn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .low_speed_osc_16khz(lso),
      .crystal_osc_32khz(xo), .i2s_word_select(ws),
      .coarse_range(8'h5A), .oscillator_trim_control(8'h80),
      .fine_trim_out(fine_trim_out), .irq(irq));
   // ---------------------------------------------------------------
   // Bus and check tasks
   // ---------------------------------------------------------------
   task automatic xfer(input logic w, input logic [7:0] a,
         input logic [31:0] d, output logic [31:0] r);
      @(posedge ref_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      do @(posedge ref_clk); while (pready !== 1'b1);
      r = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : xfer
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         failures++;
         $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task automatic end_of_test;
      $display("failures=%0d n_tests=%0d", failures, n_tests);
      if (failures == 0 && n_tests > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : end_of_test
   // ---------------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------------
   task automatic t_reset;
      logic [31:0] r;
      xfer(0, ofm_pkg::OFF_CTRL, 0, r);
      chk(r, 32'h0000_0001);
      xfer(0, ofm_pkg::OFF_COUNT, 0, r);
      chk(r, 32'h0000_0000);
      xfer(1, ofm_pkg::OFF_TRIM, 32'h0000_FFFF, r);
      xfer(0, ofm_pkg::OFF_TRIM, 0, r);
      chk(r, 32'h0000_5A80);
      xfer(1, 8'h40, 32'hFFFF_FFFF, r);
      chk(err, 1'b1);
      xfer(0, 8'h40, 0, r);
      chk(r, 32'h0000_0000);
   endtask : t_reset
   task automatic t_abort;
      logic [31:0] r;
      xfer(1, ofm_pkg::OFF_CTRL, 32'h80FF_0001, r);
      repeat (50) @(posedge ref_clk);
      xfer(1, ofm_pkg::OFF_CTRL, 32'h00FF_0001, r);
      xfer(0, ofm_pkg::OFF_COUNT, 0, r);
      chk(r, 32'h0000_0000);
      xfer(0, ofm_pkg::OFF_CTRL, 0, r);
      chk(r, 32'h00FF_0001);
   endtask : t_abort
   task automatic t_meas(input logic [1:0] s, input logic [7:0] c,
         input int p);
      logic [31:0] r;
      int n;
      xfer(1, ofm_pkg::OFF_IRQ_ENABLE, {31'h0000_0000, s[0]}, dmy);
      xfer(1, ofm_pkg::OFF_CTRL, {8'h80, c, 14'h0000, s}, r);
      xfer(0, ofm_pkg::OFF_CTRL, 0, r);
      chk(r[2], 1'b0);
      n = 0;
      while (r[2] !== 1'b1 && n < 1000) begin
         xfer(0, ofm_pkg::OFF_CTRL, 0, r);
         n++;
      end
      chk(r[2], 1'b1);
      chk(irq, s[0]);
      xfer(0, ofm_pkg::OFF_COUNT, 0, r);
      chk(r, (c + 1) * p);
      xfer(1, ofm_pkg::OFF_CTRL, {8'h00, c, 14'h0000, s}, r);
      xfer(0, ofm_pkg::OFF_COUNT, 0, r);
      chk(r, 32'h0000_0000);
      xfer(1, ofm_pkg::OFF_IRQ_CLEAR, 32'h0000_0001, r);
      xfer(0, ofm_pkg::OFF_IRQ_STATUS, 0, r);
      chk(r, 32'h0000_0000);
      chk(irq, 1'b0);
   endtask : t_meas
   task automatic t_dith(input logic [7:0] f, input logic [7:0] adj,
         input int e);
      logic [31:0] r;
      int n;
      xfer(1, ofm_pkg::OFF_TRIM, {8'h00, f, 16'h0000}, r);
      xfer(0, ofm_pkg::OFF_TRIM, 0, r);
      chk(r[23:16], f);
      n = 0;
      repeat (128) begin
         @(posedge ref_clk);
         if (fine_trim_out === adj) n++;
      end
      chk(n, e);
   endtask : t_dith
   initial begin
      repeat (3) @(posedge ref_clk);
      rstn <= 1'b1;
      t_reset;
      t_abort;
      t_meas(2'h0, 8'h01, 40);
      t_meas(2'h1, 8'h03, 20);
      t_meas(2'h2, 8'h00, 12);
      t_meas(2'h3, 8'h07, 12);
      t_dith(8'h40, 8'h81, 64);
      t_dith(8'hE0, 8'h7F, 32);
      t_dith(8'h00, 8'h81, 0);
      end_of_test;
   end
   initial begin
      #100_000;
      failures++;
      end_of_test;
   end
endmodule : testbench
`default_nettype wire
